//--- shared/sarc_pkg.sv
// Purpose: constants and types for the standby and reset controller
// Assumes: one system clock ref_clk, APB register access
// Notes: shared by the controller, its checker and the testbench
// Operation
// - halt enters standby only with flag clear
// - leaving standby through wake sets flag
// - halt with flag set: stay, flag follows wake
// - wake already true at halt: stay, set flag
// - reset resumes at zero, wake resumes next
// - operands 000/011: stop, all scan high
// - operand 110: stop, scan pin zero high
// - bit 3 adds sense pins as wake
// - operand x101: halt, wake on timer zero
// - illegal operand or precondition: internal reset
// - stop clears all timer bits first
// - wake must outlast oscillator wait or resleep
// - reset pin low: oscillator stopped, pins grounded
// - count 246 to 694 clocks after release
// - supply monitor drives reset pin low
// - reset zeroes counter, pointers, timer and flags
// - data kept only when reset during standby
// - reset loads port and control registers
// - zero rotate or stack fault resets
// - timer runs in halt, frozen at stop
package sarc_pkg;
	localparam int SCAN_W = 8;
	localparam int KEY_W = 4;
	localparam int APB_AW = 8;
	localparam int CNT_W = 16;
	localparam logic [2:0] OP_STOP_ALL = 3'h0;
	localparam logic [2:0] OP_STOP_ALT = 3'h3;
	localparam logic [2:0] OP_STOP_ONE = 3'h6;
	localparam logic [2:0] OP_HALT_TMR = 3'h5;
	localparam int OP_SENSE_BIT = 3;
	localparam int SCAN_ONE_BIT = 0;
	localparam logic [CNT_W-1:0] RST_WAIT_CYC = 16'h00f6;
	localparam logic [CNT_W-1:0] OSC_WAIT_DEF = 16'h0100;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [7:0] P0_RST = 8'hff;
	localparam logic [3:0] P1_LOW_RST = 4'hf;
	localparam logic [7:0] P3_RST = 8'h03;
	localparam logic [7:0] P4_RST = 8'h26;
	localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] REG_CAUSE = 8'h08;
	localparam logic [APB_AW-1:0] REG_OSCWAIT = 8'h0c;
	localparam int CTRL_FLAGCLR_BIT = 0;
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_SUPPLY = 1;
	localparam int CAUSE_HALT = 2;
	localparam int CAUSE_ROTATE = 3;
	localparam int CAUSE_STACK = 4;
	localparam int CAUSE_W = 5;
	localparam int SY_KEY = 0;
	localparam int SY_SA = 4;
	localparam int SY_SB = 5;
	localparam int SY_RSTPIN = 6;
	localparam int SY_SUPPLY = 7;
	localparam int SYNC_W = 8;
	typedef enum logic [2:0] {
		ST_HOLD, ST_RSTWAIT, ST_RUN, ST_TMRCLR, ST_STOP, ST_OSCWAIT, ST_HALT
	} sarc_state_t;
	typedef struct packed {
		logic exec;
		logic [3:0] operand;
	} sarc_halt_req_t;
	typedef struct packed {
		logic rotateExec;
		logic accZero;
		logic stackOver;
		logic stackUnder;
	} sarc_fault_t;
	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p3;
		logic [7:0] p4;
	} sarc_init_t;
	typedef struct packed {
		logic retain;
		logic flag;
		sarc_state_t state;
	} sarc_status_t;
endpackage : sarc_pkg

//--- hdl/sarc_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module sarc_sync #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] stage1Reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stage1Reg <= '0;
			q <= '0;
		end else if (ce) begin
			stage1Reg <= d;
			q <= stage1Reg;
		end
	end
endmodule : sarc_sync

//--- hdl/sarc_standby_reset.sv
// Purpose: standby entry and wake, system reset sequencing
// Assumes: cpu side signals on ref_clk, pins asynchronous
// Notes: registers reached over APB, zero wait states
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sarc_standby_reset #(
	parameter logic [15:0] OSC_WAIT_INIT = sarc_pkg::OSC_WAIT_DEF
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sarc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sarc_pkg::sarc_halt_req_t haltReq,
	input wire sarc_pkg::sarc_fault_t faultIn,
	input wire logic [sarc_pkg::SCAN_W-1:0] scanDriveHigh,
	input wire logic senseAIsInput,
	input wire logic senseBIsInput,
	input wire logic timerZero,
	input wire logic [sarc_pkg::KEY_W-1:0] keyInputPins,
	input wire logic senseInputA,
	input wire logic senseInputB,
	input wire logic supplyMonitorReset,
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOeN,
	output logic sysReset,
	output logic oscStop,
	output logic oscPinsLow,
	output logic cpuHold,
	output logic timerClear,
	output logic timerFreeze,
	output logic pcToZero,
	output logic resumeNext,
	output logic statusFlag,
	output logic dataRetain,
	output sarc_pkg::sarc_init_t initPorts
);
	import sarc_pkg::*;

	logic [SYNC_W-1:0] syncQ;
	sarc_state_t stateReg;
	sarc_state_t stateNext;
	logic [CNT_W-1:0] waitReg;
	logic [CNT_W-1:0] waitNext;
	logic [CNT_W-1:0] oscWaitReg;
	logic senseSelReg;
	logic senseSelNext;
	logic [CAUSE_W-1:0] causeReg;
	logic [CAUSE_W-1:0] causeSet;
	logic [CAUSE_W-1:0] causeClr;
	logic [2:0] opLow;
	logic isStop;
	logic isHalt;
	logic precondOk;
	logic keyAny;
	logic senseAny;
	logic reqWake;
	logic stopWake;
	logic pinLow;
	logic supplyLow;
	logic extReset;
	logic rotateFault;
	logic stackFault;
	logic haltFault;
	logic flagSet;
	logic flagClr;
	logic wakeDone;
	logic apbWr;
	logic addrHit;
	logic swFlagClr;
	logic inStandby;
	sarc_status_t statusWord;

	sarc_sync #(
		.W(SYNC_W)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.d({supplyMonitorReset, resetPinIn, senseInputB, senseInputA,
			keyInputPins}),
		.q(syncQ)
	);

	// wake and precondition decode
	always_comb begin
		opLow = haltReq.operand[2:0];
		isStop = (opLow == OP_STOP_ALL) || (opLow == OP_STOP_ALT) ||
			(opLow == OP_STOP_ONE);
		isHalt = (opLow == OP_HALT_TMR);
		if (opLow == OP_STOP_ONE) begin
			precondOk = scanDriveHigh[SCAN_ONE_BIT];
		end else begin
			precondOk = &scanDriveHigh;
		end
		keyAny = |syncQ[SY_KEY +: KEY_W];
		// only pins in input mode may wake
		senseAny = (syncQ[SY_SA] & senseAIsInput) |
			(syncQ[SY_SB] & senseBIsInput);
		if (isHalt) begin
			reqWake = timerZero;
		end else begin
			reqWake = keyAny | (haltReq.operand[OP_SENSE_BIT] & senseAny);
		end
		stopWake = keyAny | (senseSelReg & senseAny);
		pinLow = !syncQ[SY_RSTPIN];
		supplyLow = syncQ[SY_SUPPLY];
		extReset = pinLow | supplyLow;
		rotateFault = faultIn.rotateExec & faultIn.accZero;
		stackFault = faultIn.stackOver | faultIn.stackUnder;
		inStandby = (stateReg == ST_TMRCLR) || (stateReg == ST_STOP) ||
			(stateReg == ST_OSCWAIT) || (stateReg == ST_HALT);
	end

	// sequencing
	always_comb begin
		stateNext = stateReg;
		waitNext = waitReg;
		senseSelNext = senseSelReg;
		haltFault = 1'b0;
		flagSet = 1'b0;
		flagClr = 1'b0;
		wakeDone = 1'b0;
		if (extReset) begin
			stateNext = ST_HOLD;
		end else begin
			unique case (stateReg)
				ST_HOLD: begin
					stateNext = ST_RSTWAIT;
					waitNext = '0;
				end
				ST_RSTWAIT: begin
					if (waitReg == RST_WAIT_CYC - CNT_ONE) begin
						stateNext = ST_RUN;
					end else begin
						waitNext = waitReg + CNT_ONE;
					end
				end
				ST_RUN: begin
					if (rotateFault || stackFault) begin
						stateNext = ST_HOLD;
					end else if (haltReq.exec) begin
						if (statusFlag) begin
							flagSet = reqWake;
							flagClr = !reqWake;
						end else if (!isHalt && !(isStop && precondOk)) begin
							stateNext = ST_HOLD;
							haltFault = 1'b1;
						end else if (reqWake) begin
							flagSet = 1'b1;
						end else if (isHalt) begin
							stateNext = ST_HALT;
						end else begin
							senseSelNext = haltReq.operand[OP_SENSE_BIT];
							// running timer is cleared before stopping
							if (timerZero) begin
								stateNext = ST_STOP;
							end else begin
								stateNext = ST_TMRCLR;
							end
						end
					end
				end
				ST_TMRCLR: begin
					if (timerZero) begin
						stateNext = ST_STOP;
					end
				end
				ST_STOP: begin
					if (stopWake) begin
						stateNext = ST_OSCWAIT;
						waitNext = '0;
					end
				end
				ST_OSCWAIT: begin
					if (waitReg + CNT_ONE >= oscWaitReg) begin
						// wake gone by the end of the wait: sleep again
						if (stopWake) begin
							stateNext = ST_RUN;
							flagSet = 1'b1;
							wakeDone = 1'b1;
						end else begin
							stateNext = ST_STOP;
						end
					end else begin
						waitNext = waitReg + CNT_ONE;
					end
				end
				ST_HALT: begin
					if (timerZero) begin
						stateNext = ST_RUN;
						flagSet = 1'b1;
						wakeDone = 1'b1;
					end
				end
				default: begin
					stateNext = ST_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stateReg <= ST_HOLD;
			waitReg <= '0;
			senseSelReg <= 1'b0;
		end else if (ce) begin
			stateReg <= stateNext;
			waitReg <= waitNext;
			senseSelReg <= senseSelNext;
		end
	end

	// status flag: reset clear wins over all, then hardware set wins over flag clears
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			statusFlag <= 1'b0;
		end else if (ce) begin
			if (stateNext == ST_HOLD) begin
				statusFlag <= 1'b0;
			end else if (flagSet) begin
				statusFlag <= 1'b1;
			end else if (flagClr || swFlagClr) begin
				statusFlag <= 1'b0;
			end
		end
	end

	// control outputs, all registered: levels from the next state, pcToZero and resumeNext from the transition
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sysReset <= 1'b1;
			oscStop <= 1'b1;
			oscPinsLow <= 1'b1;
			cpuHold <= 1'b0;
			timerClear <= 1'b1;
			timerFreeze <= 1'b0;
			pcToZero <= 1'b0;
			resumeNext <= 1'b0;
		end else if (ce) begin
			sysReset <= (stateNext == ST_HOLD) ||
				(stateNext == ST_RSTWAIT);
			oscStop <= (stateNext == ST_HOLD) ||
				(stateNext == ST_STOP);
			oscPinsLow <= (stateNext == ST_HOLD) ||
				(stateNext == ST_STOP);
			cpuHold <= (stateNext == ST_TMRCLR) || (stateNext == ST_STOP) ||
				(stateNext == ST_OSCWAIT) || (stateNext == ST_HALT);
			timerClear <= (stateNext == ST_HOLD) ||
				(stateNext == ST_TMRCLR);
			timerFreeze <= (stateNext == ST_STOP) ||
				(stateNext == ST_OSCWAIT);
			pcToZero <= (stateReg == ST_RSTWAIT) &&
				(stateNext == ST_RUN);
			resumeNext <= wakeDone;
		end
	end

	// reset pin is open drain: pulled low while the monitor holds reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resetPinOut <= 1'b0;
			resetPinOeN <= 1'b1;
		end else if (ce) begin
			resetPinOut <= 1'b0;
			resetPinOeN <= !supplyLow;
		end
	end

	// reset loads and data retention
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dataRetain <= 1'b0;
			initPorts <= '{P0_RST, {4'h0, P1_LOW_RST}, P3_RST, P4_RST};
		end else if (ce) begin
			if ((stateNext == ST_HOLD) && (stateReg != ST_HOLD)) begin
				dataRetain <= inStandby;
			end
			if (stateNext == ST_HOLD) begin
				initPorts <= '{P0_RST, {syncQ[SY_KEY +: KEY_W], P1_LOW_RST},
					P3_RST, P4_RST};
			end
		end
	end

	// reset cause capture
	always_comb begin
		causeSet = '0;
		causeSet[CAUSE_PIN] = pinLow;
		causeSet[CAUSE_SUPPLY] = supplyLow;
		causeSet[CAUSE_HALT] = haltFault;
		causeSet[CAUSE_ROTATE] = rotateFault && (stateReg == ST_RUN);
		causeSet[CAUSE_STACK] = stackFault && (stateReg == ST_RUN);
		causeClr = '0;
		if (apbWr && (paddr == REG_CAUSE)) begin
			causeClr = pwdata[CAUSE_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			causeReg <= '0;
		end else if (ce) begin
			causeReg <= causeSet | (causeReg & ~causeClr);
		end
	end

	// APB slave
	always_comb begin
		apbWr = psel && penable && pready && pwrite;
		addrHit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
			(paddr == REG_CAUSE) || (paddr == REG_OSCWAIT);
		swFlagClr = apbWr && (paddr == REG_CTRL) &&
			pwdata[CTRL_FLAGCLR_BIT];
		statusWord = '{dataRetain, statusFlag, stateReg};
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addrHit;
			if (psel && !penable) begin
				unique case (paddr)
					REG_STATUS: prdata <= 32'(statusWord);
					REG_CAUSE: prdata <= 32'(causeReg);
					REG_OSCWAIT: prdata <= 32'(oscWaitReg);
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			oscWaitReg <= OSC_WAIT_INIT;
		end else if (ce) begin
			if (apbWr && (paddr == REG_OSCWAIT)) begin
				oscWaitReg <= pwdata[CNT_W-1:0];
			end
		end
	end
endmodule : sarc_standby_reset

//--- dv/sarc_checker_assertions.sv
// Purpose: concurrent checks on the standby and reset controller
// Assumes: bound to the top module, one clock domain
// Notes: cntReg counts cycles of the post-release reset count
`timescale 1ns/1ps
module sarc_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire sarc_pkg::sarc_halt_req_t haltReq,
	input wire sarc_pkg::sarc_fault_t faultIn,
	input wire logic timerZero,
	input wire logic resetPinIn,
	input wire logic sysReset,
	input wire logic oscStop,
	input wire logic oscPinsLow,
	input wire logic cpuHold,
	input wire logic timerClear,
	input wire logic timerFreeze,
	input wire logic pcToZero,
	input wire logic resumeNext,
	input wire logic statusFlag
);
	import sarc_pkg::*;
	logic [9:0] cntReg;
	logic run;
	logic fault;
	assign run = !sysReset && !cpuHold;
	assign fault = faultIn.rotateExec && faultIn.accZero
		|| faultIn.stackOver || faultIn.stackUnder;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			cntReg <= '0;
		else if (!sysReset || oscStop)
			cntReg <= '0;
		else if (cntReg != 10'h3ff)
			cntReg <= cntReg + 10'h001;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	osc_hold_a: assert property (
		!resetPinIn [*5] |-> sysReset && oscStop && oscPinsLow)
		else $error("pin reset not held");
	rst_count_a: assert property (
		$fell(sysReset) |-> cntReg >= 10'h0f6 && cntReg <= 10'h2b6)
		else $error("reset count out of range");
	pc_zero_a: assert property (
		$fell(sysReset) |-> ##[0:2] pcToZero)
		else $error("no restart at zero");
	stop_freeze_a: assert property (
		oscStop && !sysReset |-> timerFreeze && cpuHold)
		else $error("stop without frozen timer");
	stop_clear_a: assert property (
		timerClear && !sysReset && !timerZero |=> !oscStop)
		else $error("stop before timer cleared");
	halt_wake_a: assert property (
		ce && !sysReset && cpuHold && !timerFreeze && !timerClear && timerZero
		|=> !cpuHold && statusFlag && resumeNext)
		else $error("halt not left on timer zero");
	flag_busy_a: assert property (
		haltReq.exec && statusFlag && run |=> !cpuHold && !sysReset)
		else $error("standby entered with flag set");
	illegal_op_a: assert property (
		haltReq.exec && !statusFlag && run
		&& !(haltReq.operand[2:0] inside {3'h0, 3'h3, 3'h5, 3'h6})
		|-> ##[1:3] sysReset)
		else $error("illegal operand without reset");
	fault_rst_a: assert property (
		run && fault |-> ##[1:3] sysReset)
		else $error("fault without reset");
	cover property (resumeNext && !cpuHold);
	cover property ($rose(oscStop) && !sysReset);
	cover property ($fell(sysReset));
endmodule : sarc_checker

//--- dv/sarc_far_side.sv
// Purpose: key matrix, sense pins and external reset driver
// Assumes: reset pin pulled up, key pins pulled down
// Notes: external reset sinks the pin, never drives it high
`timescale 1ns/1ps
module sarc_far_side (
	input wire logic [3:0] keyReq,
	input wire logic [1:0] senseReq,
	input wire logic extLow,
	input wire logic resetPinOeN,
	output logic [3:0] keyInputPins,
	output logic senseInputA,
	output logic senseInputB,
	output logic resetPinIn
);
	// open drain on both sides, pull-up otherwise
	assign resetPinIn = !(extLow || !resetPinOeN);
	// key 3 kept low while the pin is in reset
	assign keyInputPins = resetPinIn ? keyReq : {1'b0, keyReq[2:0]};
	assign senseInputA = senseReq[0];
	assign senseInputB = senseReq[1];
endmodule : sarc_far_side

//--- dv/testbench.sv
// Purpose: self-checking bench for the standby and reset controller
// Assumes: 50 MHz ref_clk, far side model on the pins
// Notes: random operand bit 3, wake pins and wait length
`timescale 1ns/1ps
module testbench;
	import sarc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, resetPinIn, resetPinOeN, senseInputA, senseInputB;
	logic resetPinOut;
	logic ce = 1'b1;
	sarc_halt_req_t haltReq = '0;
	sarc_fault_t faultIn = '0;
	logic [7:0] scanDriveHigh = 8'hff;
	logic timerZero = 1'b1;
	logic supplyMonitorReset = 1'b0;
	logic extLow = 1'b0;
	logic [3:0] keyReq = 4'h0;
	logic [1:0] senseReq = 2'h0;
	logic [3:0] keyInputPins;
	logic sysReset, oscStop, cpuHold, timerClear, pcToZero;
	logic resumeNext, statusFlag, dataRetain;
	sarc_init_t initPorts;
	int n_mismatch = 0;
	int n_compared = 0;
	int pcCnt = 0;
	int wakeCnt = 0;
	int cycles = 0;
	always #10 ref_clk = ~ref_clk;
	// both sense pins kept as inputs
	sarc_standby_reset #(.OSC_WAIT_INIT(16'h0004)) i_dut (.ref_clk, .rst,
		.ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .haltReq, .faultIn, .scanDriveHigh,
		.senseAIsInput(1'b1), .senseBIsInput(1'b1), .timerZero,
		.keyInputPins, .senseInputA, .senseInputB, .supplyMonitorReset,
		.resetPinIn, .resetPinOut, .resetPinOeN, .sysReset, .oscStop,
		.oscPinsLow(), .cpuHold, .timerClear, .timerFreeze(), .pcToZero,
		.resumeNext, .statusFlag, .dataRetain, .initPorts);
	sarc_far_side i_far (.keyReq, .senseReq, .extLow, .resetPinOeN,
		.keyInputPins, .senseInputA, .senseInputB, .resetPinIn);
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	always @(posedge ref_clk) begin
		cycles++;
		pcCnt += int'(pcToZero === 1'b1);
		wakeCnt += int'(resumeNext === 1'b1);
		if (cycles == 40000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'b1;
		do cyc(1); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cyc(1);
	endtask : apb
	task automatic halt(logic [3:0] op);
		haltReq <= '{1'b1, op};
		cyc(1);
		haltReq.exec <= 1'b0;
		cyc(3);
	endtask : halt
	task automatic waitRun();
		do cyc(1); while (sysReset !== 1'b0 || cpuHold !== 1'b0);
		cyc(2);
	endtask : waitRun
	task automatic fin(string s);
		$display("test %s done, mismatches %0d", s, n_mismatch);
	endtask : fin
	initial begin
		logic [31:0] q;
		logic e;
		logic [3:0] op;
		logic [31:0] p;
		static logic [3:0] bad [6] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h0, 4'h6};
		static logic [3:0] flt [4] = '{4'hc, 4'h2, 4'h1, 4'h8};
		void'($urandom(25));
		cyc(20);
		rst <= 1'b0;
		cyc(5);
		waitRun();
		chk("pcToZero", 1, pcCnt);
		chk("initPorts", 32'hff0f_0326, initPorts);
		apb(1'b0, REG_STATUS, 0, q, e);
		chk("status", 2, q);
		p = 8 + $urandom % 8;
		apb(1'b1, REG_OSCWAIT, p, q, e);
		apb(1'b0, REG_OSCWAIT, 0, q, e);
		chk("oscWait", p, q);
		apb(1'b0, 8'h10, 0, q, e);
		chk("unmapped", 1, {q[30:0], e});
		fin("reset");
		timerZero <= 1'b0;
		op = {1'($urandom), 3'h5};
		halt(op);
		chk("haltHold", 1, cpuHold);
		ce <= 1'b0;
		timerZero <= 1'b1;
		cyc(4);
		chk("ceFreeze", 1, cpuHold);
		ce <= 1'b1;
		cyc(4);
		chk("haltWake", 32'h0000_0011, {statusFlag, cpuHold, wakeCnt[2:0]});
		halt(op);
		chk("busyStay", 1, {cpuHold, statusFlag});
		timerZero <= 1'b0;
		halt(op);
		chk("busyClr", 0, {cpuHold, statusFlag});
		timerZero <= 1'b1;
		halt(op);
		chk("preWake", 1, {cpuHold, statusFlag});
		apb(1'b1, REG_CTRL, 1, q, e);
		fin("halt");
		for (int i = 0; i < 3; i++) begin
			op = {1'($urandom), 3'(3 * i)};
			scanDriveHigh <= i == 2 ? 8'h01 : 8'hff;
			timerZero <= 1'b0;
			halt(op);
			chk("tmrClr", 2, {timerClear, oscStop});
			timerZero <= 1'b1;
			cyc(3);
			chk("stop", 3, {cpuHold, oscStop});
			keyReq <= 4'(1 << $urandom % 4);
			cyc(3);
			keyReq <= 4'h0;
			cyc(30);
			chk("reSleep", 3, {oscStop, ~statusFlag});
			if (op[3] && $urandom % 2)
				senseReq <= 2'(1 << $urandom % 2);
			else
				keyReq <= 4'(1 << $urandom % 4);
			cyc(30);
			chk("stopWake", 1, {oscStop, cpuHold, statusFlag});
			keyReq <= 4'h0; // idle step after wake
			senseReq <= 2'h0;
			apb(1'b1, REG_CTRL, 1, q, e);
		end
		scanDriveHigh <= 8'hff;
		halt(4'h0);
		supplyMonitorReset <= 1'b1;
		cyc(6);
		chk("supply", 3, {resetPinOut, resetPinOeN, oscStop, sysReset});
		supplyMonitorReset <= 1'b0;
		cyc(4);
		waitRun();
		chk("retain", 32'h0000_0012, {dataRetain, statusFlag, pcCnt[2:0]});
		fin("stop");
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, REG_CAUSE, 32'h0000_001f, q, e);
			scanDriveHigh <= i == 4 ? 8'h7f : i == 5 ? 8'hfe : 8'hff;
			halt(bad[i]);
			waitRun();
			apb(1'b0, REG_CAUSE, 0, q, e);
			chk("haltBad", 4, q);
		end
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, REG_CAUSE, 32'h0000_001f, q, e);
			faultIn <= flt[i];
			cyc(1);
			faultIn <= '0;
			cyc(3);
			chk("faultRst", i < 3, sysReset);
			waitRun();
			apb(1'b0, REG_CAUSE, 0, q, e);
			chk("cause", i == 0 ? 8 : i < 3 ? 16 : 0, q);
		end
		fin("faults");
		extLow <= 1'b1;
		cyc(6);
		chk("pinRst", 3, {oscStop, sysReset});
		extLow <= 1'b0;
		cyc(4);
		waitRun();
		chk("pinRun", 12, pcCnt);
		fin("pin");
		results();
	end
endmodule : testbench
bind sarc_standby_reset sarc_checker i_chk (.ref_clk, .rst, .ce, .haltReq,
	.faultIn, .timerZero, .resetPinIn, .sysReset, .oscStop, .oscPinsLow,
	.cpuHold, .timerClear, .timerFreeze, .pcToZero, .resumeNext,
	.statusFlag);
